// file: inc/pgtm_params.svh
// Purpose: Offsets, field positions and reset values of the PG tree masks
// Assumes: Byte-wide registers on an 8-bit register address
// Notes:   Reset values stand in for the factory-programmed defaults
`ifndef PGTM_PARAMS_SVH
`define PGTM_PARAMS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define PGTM_OFS_FOUR_LOW 8'ha6
`define PGTM_OFS_FOUR_HIGH 8'ha7
`define PGTM_OFS_TWO_LOW 8'ha8

// ----------------------------------------------------------------------
// Low mask layout (rails)
// ----------------------------------------------------------------------
`define PGTM_BIT_LINEAR_REG_TWO 7
`define PGTM_BIT_LOAD_SWITCH_A 6
`define PGTM_BIT_STEP_DOWN_6 5
`define PGTM_BIT_STEP_DOWN_1 0

// ----------------------------------------------------------------------
// High mask layout (control pins and remaining rails)
// ----------------------------------------------------------------------
`define PGTM_BIT_CONTROL_INPUT_5 7
`define PGTM_BIT_CONTROL_INPUT_4 6
`define PGTM_BIT_CONTROL_INPUT_2 5
`define PGTM_BIT_CONTROL_INPUT_1 4
`define PGTM_BIT_TERMINATION_LDO 3
`define PGTM_BIT_SHARED 2
`define PGTM_BIT_LOAD_SWITCH_B1 1
`define PGTM_BIT_LINEAR_REG_THREE 0

// ----------------------------------------------------------------------
// Reset values (all inputs masked) and variant strap
// ----------------------------------------------------------------------
`define PGTM_RST_FOUR_LOW 8'hff
`define PGTM_RST_FOUR_HIGH 8'hff
`define PGTM_RST_TWO_LOW 8'hff
// 1: shared bit watches load_switch_b2, 0: linear_reg_one
`define PGTM_SHARED_IS_SWITCH 1'b0

`endif

// file: inc/pgtm_pkg.sv
// Purpose: Types shared by the PG tree mask block
// Assumes: Constants come from pgtm_params.svh
// Notes:   Types only
package pgtm_pkg;
  typedef logic [7:0] pgtm_byte_t;
endpackage

// file: hw/pgtm_top.sv
// Purpose: Mask registers and power-good trees for output pins four and two
// Assumes: Register port is synchronous to clk_i; rail and pin inputs async
// Notes:   Outputs are registered; rail and pin inputs pass a two-flop synchroniser
`timescale 1ns/1ns
`default_nettype none
`include "pgtm_params.svh"

module pgtm_top
  import pgtm_pkg::*;
(
  // Clock, reset and enable
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  // Register port
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  output logic reg_hit_o,
  // Rail power-good inputs, low-mask order
  input wire logic [7:0] rail_pg_i,
  // Control-pin and rail inputs, high-mask order, bit 2 unused
  input wire logic [7:0] aux_pg_i,
  // Variant inputs sharing high-mask bit 2
  input wire logic load_switch_b2_pg_i,
  input wire logic linear_reg_one_pg_i,
  // Power-good tree outputs
  output logic output_pin_four_o,
  output logic output_pin_two_o
);

  // ----------------------------------------------------------------------
  // Tree reduction
  // ----------------------------------------------------------------------
  // Good when every input is good or masked off
  function automatic logic pgtm_tree(input pgtm_byte_t pg,
                                     input pgtm_byte_t msk);
    pgtm_tree = &(pg | msk);
  endfunction

  // ----------------------------------------------------------------------
  // Input synchroniser
  // ----------------------------------------------------------------------
  logic [16:0] raw_in;
  logic [16:0] sync1_q;
  logic [16:0] sync2_q;
  pgtm_byte_t rail_s;
  pgtm_byte_t aux_s;
  logic shared_raw;

  // Variant strap picks the shared input
  assign shared_raw = `PGTM_SHARED_IS_SWITCH ? load_switch_b2_pg_i
                                             : linear_reg_one_pg_i;
  assign raw_in = {shared_raw, aux_pg_i, rail_pg_i};

  // Two flops per bit, first stage read only by the second
  genvar gi;
  generate
    for (gi = 0; gi < 17; gi++) begin : g_sync
      always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          sync1_q[gi] <= 1'b0;
          sync2_q[gi] <= 1'b0;
        end else if (ce_i) begin
          sync1_q[gi] <= raw_in[gi];
          sync2_q[gi] <= sync1_q[gi];
        end
      end
    end
  endgenerate

  assign rail_s = sync2_q[7:0];
  assign aux_s = {sync2_q[15:11], sync2_q[16], sync2_q[9:8]};

  // ----------------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------------
  logic hit_four_lo;
  logic hit_four_hi;
  logic hit_two_lo;
  logic hit_any;

  assign hit_four_lo = reg_addr_i == `PGTM_OFS_FOUR_LOW;
  assign hit_four_hi = reg_addr_i == `PGTM_OFS_FOUR_HIGH;
  assign hit_two_lo = reg_addr_i == `PGTM_OFS_TWO_LOW;
  assign hit_any = hit_four_lo | hit_four_hi | hit_two_lo;

  // ----------------------------------------------------------------------
  // Mask registers
  // ----------------------------------------------------------------------
  pgtm_byte_t four_lo_q;
  pgtm_byte_t four_hi_q;
  pgtm_byte_t two_lo_q;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      four_lo_q <= `PGTM_RST_FOUR_LOW;
    end else if (ce_i && reg_wr_i && hit_four_lo) begin
      four_lo_q <= reg_wdata_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      four_hi_q <= `PGTM_RST_FOUR_HIGH;
    end else if (ce_i && reg_wr_i && hit_four_hi) begin
      four_hi_q <= reg_wdata_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      two_lo_q <= `PGTM_RST_TWO_LOW;
    end else if (ce_i && reg_wr_i && hit_two_lo) begin
      two_lo_q <= reg_wdata_i;
    end
  end

  // ----------------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------------
  pgtm_byte_t rdata_d;

  // Unmapped offsets read as zero
  assign rdata_d = hit_four_lo ? four_lo_q :
                   hit_four_hi ? four_hi_q :
                   hit_two_lo ? two_lo_q : 8'h00;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      reg_rdata_o <= 8'h00;
      reg_hit_o <= 1'b0;
    end else if (ce_i) begin
      reg_rdata_o <= reg_rd_i ? rdata_d : 8'h00;
      reg_hit_o <= (reg_rd_i | reg_wr_i) & hit_any;
    end
  end

  // ----------------------------------------------------------------------
  // Power-good trees
  // ----------------------------------------------------------------------
  logic four_good_d;
  logic two_good_d;

  assign four_good_d = pgtm_tree(rail_s, four_lo_q) &
                       pgtm_tree(aux_s, four_hi_q);
  assign two_good_d = pgtm_tree(rail_s, two_lo_q);

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      output_pin_four_o <= 1'b0;
      output_pin_two_o <= 1'b0;
    end else if (ce_i) begin
      output_pin_four_o <= four_good_d;
      output_pin_two_o <= two_good_d;
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  property p_low_store;
    ce_i && reg_wr_i && reg_addr_i == `PGTM_OFS_FOUR_LOW
      |=> four_lo_q == $past(reg_wdata_i);
  endproperty
  a_low_store: assert property (p_low_store)
    else $error("pin four low mask not stored");

  property p_include;
    ce_i && !four_lo_q[`PGTM_BIT_STEP_DOWN_1] && !rail_s[0]
      |=> !output_pin_four_o;
  endproperty
  a_include: assert property (p_include)
    else $error("unmasked bad rail did not drop pin four");

  property p_exclude;
    ce_i && four_lo_q == 8'hff && four_hi_q == 8'hff |=> output_pin_four_o;
  endproperty
  a_exclude: assert property (p_exclude)
    else $error("fully masked pin four not good");

  property p_ctl_five;
    ce_i && !four_hi_q[`PGTM_BIT_CONTROL_INPUT_5] && !aux_s[7]
      |=> !output_pin_four_o;
  endproperty
  a_ctl_five: assert property (p_ctl_five)
    else $error("control input 5 not in pin four tree");

  property p_term;
    ce_i && !four_hi_q[`PGTM_BIT_TERMINATION_LDO] && !sync2_q[11]
      |=> !output_pin_four_o;
  endproperty
  a_term: assert property (p_term)
    else $error("termination ldo not in pin four tree");

  property p_shared;
    ce_i && !four_hi_q[`PGTM_BIT_SHARED] && !sync2_q[16]
      |=> !output_pin_four_o;
  endproperty
  a_shared: assert property (p_shared)
    else $error("shared input not in pin four tree");

  property p_two;
    ce_i && !two_lo_q[`PGTM_BIT_LINEAR_REG_TWO] && !rail_s[7]
      |=> !output_pin_two_o;
  endproperty
  a_two: assert property (p_two)
    else $error("linear reg two not in pin two tree");

  property p_all_good;
    ce_i && rail_s == 8'hff && sync2_q[16:8] == 9'h1ff
      |=> output_pin_four_o && output_pin_two_o;
  endproperty
  a_all_good: assert property (p_all_good)
    else $error("all inputs good but pin not good");

  property p_cov_drop;
    ce_i && output_pin_four_o ##1 ce_i && !output_pin_four_o;
  endproperty
  c_cov_drop: cover property (p_cov_drop);

  property p_cov_two_good;
    ce_i && two_lo_q != 8'hff ##1 output_pin_two_o;
  endproperty
  c_cov_two_good: cover property (p_cov_two_good);

  property p_cov_read;
    ce_i && reg_rd_i && hit_four_hi ##1 reg_hit_o;
  endproperty
  c_cov_read: cover property (p_cov_read);

endmodule // pgtm_top

`default_nettype wire

// file: test/pgtm_sys_mon.sv
// Purpose: System logic that watches the two power-good pins
// Assumes: Pins are registered levels, high means good
// Notes:   Samples each edge, as downstream logic would
`timescale 1ns/1ns
`default_nettype none

module pgtm_sys_mon (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Pins watched
  input wire logic output_pin_four_i,
  input wire logic output_pin_two_i,
  // Levels seen downstream
  output logic four_seen_o,
  output logic two_seen_o
);
  // Capture pin levels one edge late
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      four_seen_o <= 1'b0;
      two_seen_o <= 1'b0;
    end else begin
      four_seen_o <= output_pin_four_i;
      two_seen_o <= output_pin_two_i;
    end
  end
endmodule // pgtm_sys_mon

`default_nettype wire

// file: test/pgtm_test.sv
// Purpose: Self-checking bench for the PG tree mask block
// Assumes: Design strap and reset values from pgtm_params.svh
// Notes:   Register replies checked from a queue on reg_hit_o
`timescale 1ns/1ns
`default_nettype none
`include "pgtm_params.svh"

module pgtm_test;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic ce = 1'b1;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rail = 8'h00;
  logic [7:0] aux = 8'h00;
  logic sw2 = 1'b0;
  logic ldo1 = 1'b0;
  wire logic [7:0] rdata;
  wire logic hit, four, two, four_seen, two_seen;
  logic [7:0] q[$];
  int error_cnt = 0;
  int compares = 0;
  logic [31:0] seed = 32'h0000001e;

  pgtm_top dut (.clk_i(clk), .rst_b_i(rst_b), .ce_i(ce), .reg_addr_i(addr),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
    .reg_hit_o(hit), .rail_pg_i(rail), .aux_pg_i(aux),
    .load_switch_b2_pg_i(sw2), .linear_reg_one_pg_i(ldo1),
    .output_pin_four_o(four), .output_pin_two_o(two));
  pgtm_sys_mon mon (.clk_i(clk), .rst_b_i(rst_b), .output_pin_four_i(four),
    .output_pin_two_i(two), .four_seen_o(four_seen), .two_seen_o(two_seen));

  // 25 MHz clock
  initial begin
    forever #20 clk = ~clk;
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Low byte of two draws ORed, biased toward masked or good
  function automatic logic [7:0] rnd8();
    logic [31:0] v;
    v = rnd() | rnd();
    return v[7:0];
  endfunction

  task automatic chk(input string nm, input logic [7:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic finish_test();
    if (error_cnt == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // One register access; a mapped one notes its reply
  task automatic acc(input logic w, input logic [7:0] a, d, e,
                     input logic mapped);
    @(posedge clk);
    wr <= w;
    rd <= !w;
    addr <= a;
    wdata <= d;
    if (mapped) q.push_back(e);
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
  endtask

  // Reply checker, sampled mid-cycle
  always @(negedge clk) begin
    if (hit === 1'b1) begin
      if (q.size() == 0) chk("unexpected hit", 8'h01, 8'h00);
      else chk("rdata", rdata, q.pop_front());
    end
  end

  // Hang guard
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    finish_test();
  end

  initial begin
    int n;
    logic [7:0] ml, mh, m2, r, a, b;
    logic [15:0] k;
    logic l1, s2, sh;
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    acc(1'b0, `PGTM_OFS_FOUR_LOW, 8'h00, `PGTM_RST_FOUR_LOW, 1'b1);
    acc(1'b0, `PGTM_OFS_FOUR_HIGH, 8'h00, `PGTM_RST_FOUR_HIGH, 1'b1);
    acc(1'b0, `PGTM_OFS_TWO_LOW, 8'h00, `PGTM_RST_TWO_LOW, 1'b1);
    repeat (4) @(posedge clk);
    @(negedge clk);
    chk("four all masked", {7'h00, four_seen}, 8'h01);
    // Unmapped offset: write ignored, read silent
    acc(1'b1, 8'ha9, 8'h00, 8'h00, 1'b0);
    acc(1'b0, 8'ha9, 8'h00, 8'h00, 1'b0);
    for (n = 0; n < 48; n++) begin
      if (n < 16) begin
        k = 16'h0001 << n;
        {mh, ml} = ~k;
        {a, r} = ~k;
        m2 = ~k[7:0];
        l1 = ~k[10];
        b = rnd8();
        s2 = b[0];
      end else begin
        ml = rnd8();
        mh = rnd8();
        m2 = rnd8();
        r = rnd8();
        a = rnd8();
        b = rnd8();
        {l1, s2} = b[1:0];
      end
      acc(1'b1, `PGTM_OFS_FOUR_LOW, ml, 8'h00, 1'b1);
      acc(1'b1, `PGTM_OFS_FOUR_HIGH, mh, 8'h00, 1'b1);
      acc(1'b1, `PGTM_OFS_TWO_LOW, m2, 8'h00, 1'b1);
      acc(1'b0, `PGTM_OFS_FOUR_LOW, 8'h00, ml, 1'b1);
      acc(1'b0, `PGTM_OFS_FOUR_HIGH, 8'h00, mh, 1'b1);
      acc(1'b0, `PGTM_OFS_TWO_LOW, 8'h00, m2, 1'b1);
      @(posedge clk);
      rail <= r;
      aux <= a;
      ldo1 <= l1;
      sw2 <= s2;
      sh = `PGTM_SHARED_IS_SWITCH ? s2 : l1;
      repeat (6) @(posedge clk);
      @(negedge clk);
      chk("four", {7'h00, four_seen},
        {7'h00, &(r | ml) & &({a[7:3], sh, a[1:0]} | mh)});
      chk("two", {7'h00, two_seen}, {7'h00, &(r | m2)});
    end
    // Second reset restores the masks
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    acc(1'b0, `PGTM_OFS_FOUR_HIGH, 8'h00, `PGTM_RST_FOUR_HIGH, 1'b1);
    // Clock enable low: a write must not land, hit stays low
    @(posedge clk);
    ce <= 1'b0;
    acc(1'b1, `PGTM_OFS_FOUR_LOW, 8'h00, 8'h00, 1'b0);
    @(posedge clk);
    ce <= 1'b1;
    acc(1'b0, `PGTM_OFS_FOUR_LOW, 8'h00, `PGTM_RST_FOUR_LOW, 1'b1);
    for (n = 0; n < 10 && q.size() != 0; n++) @(posedge clk);
    if (q.size() != 0) chk("replies left", 8'(q.size()), 8'h00);
    finish_test();
  end
endmodule // pgtm_test

`default_nettype wire
